// ---- bench/serial_pcm_instruction_decoder_checker.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "pcm_decode_map.vh"
// ----------------------------------------
// Port checker
// ----------------------------------------
module pcm_decode_checker (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic cs_n,
  input wire logic io_line_1_oe,
  input wire logic write_enable_latch,
  input wire logic busy,
  input wire logic op_done,
  input wire logic cmd_valid,
  input wire logic cmd_reject,
  input wire logic [3:0] cmd_kind,
  input wire logic [23:0] cmd_addr,
  input wire logic [6:0] cmd_sector,
  input wire logic [17:0] cmd_page,
  input wire logic [2:0] cmd_region,
  input wire logic [7:0] cmd_fill,
  input wire logic wd_valid,
  input wire logic wd_ready,
  input wire logic [13:0] wd_data
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  sequence wipe_exec_s;
    cmd_valid && cmd_kind >= `KIND_SECTOR_WIPE;
  endsequence
  // Select synchroniser plus margin
  sequence held_off_s;
    cs_n [*5];
  endsequence
  sector_map_a: assert property (cmd_valid |-> cmd_sector == cmd_addr[23:17])
    else $error("sector number off");
  page_map_a: assert property (cmd_valid |-> cmd_page == cmd_addr[23:6])
    else $error("page number off");
  region_map_a: assert property (cmd_valid |-> cmd_region == cmd_sector[6:4])
    else $error("region number off");
  fill_value_a: assert property (wipe_exec_s |-> cmd_fill == 8'hff)
    else $error("wipe fill not ones");
  valid_pulse_a: assert property (cmd_valid |=> !cmd_valid)
    else $error("execute pulse too long");
  busy_start_a: assert property (cmd_valid |-> ##[0:1] (busy && !write_enable_latch))
    else $error("busy or latch wrong after execute");
  latch_need_a: assert property (cmd_valid |-> $past(write_enable_latch, 3))
    else $error("executed without latch");
  latch_set_a: assert property ($rose(write_enable_latch) |-> cs_n && $past(cs_n, 2))
    else $error("latch set before deselect");
  busy_keep_a: assert property (busy && !op_done |=> busy && !$rose(write_enable_latch))
    else $error("busy cycle disturbed");
  oe_release_a: assert property (held_off_s |-> !io_line_1_oe)
    else $error("output driven while deselected");
  wd_hold_a: assert property (wd_valid && !wd_ready && !cmd_reject |=> wd_valid && $stable(wd_data))
    else $error("write data lost in stall");
endmodule
bind serial_pcm_instruction_decoder pcm_decode_checker chk (.mclk(mclk), .rst_n(rst_n), .cs_n(cs_n),
  .io_line_1_oe(io_line_1_oe), .write_enable_latch(write_enable_latch), .busy(busy), .op_done(op_done),
  .cmd_valid(cmd_valid), .cmd_reject(cmd_reject), .cmd_kind(cmd_kind), .cmd_addr(cmd_addr),
  .cmd_sector(cmd_sector), .cmd_page(cmd_page), .cmd_region(cmd_region), .cmd_fill(cmd_fill),
  .wd_valid(wd_valid), .wd_ready(wd_ready), .wd_data(wd_data));
`default_nettype wire

// ---- bench/serial_pcm_instruction_decoder_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "pcm_decode_map.vh"
module serial_pcm_instruction_decoder_tb;
  localparam logic [7:0] ID_M = 8'h5a; // Arbitrary value
  logic mclk, rst_n, op_done, wd_ready;
  logic [7:0] rx;
  logic [13:0] wq[$];
  int err_total = 0, tests_run = 0, nr = 0, cyc = 0;
  wire cs_n, sclk, write_enable_latch, busy, cmd_valid, cmd_reject, array_read, wd_valid;
  wire [3:0] h_io, pins, d_o, d_oe, cmd_kind;
  wire [1:0] cmd_mode;
  wire [2:0] cmd_lanes, cmd_region;
  wire [23:0] cmd_addr, array_raddr;
  wire [6:0] cmd_sector, cmd_count;
  wire [17:0] cmd_page;
  wire [7:0] cmd_fill, cmd_data, array_rdata;
  wire [13:0] wd_data;
  assign pins = (d_oe & d_o) | (~d_oe & h_io);
  assign array_rdata = array_raddr[7:0] ^ 8'ha5;
  spi_host_model host (.mclk(mclk), .io_in(pins), .cs_n(cs_n), .sclk(sclk), .io_out(h_io));
  serial_pcm_instruction_decoder #(.ID_MAKER(ID_M)) dut (.mclk(mclk), .rst_n(rst_n), .cs_n(cs_n), .sclk(sclk),
    .io_line_0_i(pins[0]), .io_line_1_i(pins[1]), .io_line_2_i(pins[2]), .io_line_3_i(pins[3]),
    .io_line_0_o(d_o[0]), .io_line_1_o(d_o[1]), .io_line_2_o(d_o[2]), .io_line_3_o(d_o[3]),
    .io_line_0_oe(d_oe[0]), .io_line_1_oe(d_oe[1]), .io_line_2_oe(d_oe[2]), .io_line_3_oe(d_oe[3]),
    .write_enable_latch(write_enable_latch), .busy(busy), .op_done(op_done), .cmd_valid(cmd_valid),
    .cmd_reject(cmd_reject), .cmd_kind(cmd_kind), .cmd_mode(cmd_mode), .cmd_lanes(cmd_lanes),
    .cmd_addr(cmd_addr), .cmd_sector(cmd_sector), .cmd_page(cmd_page), .cmd_region(cmd_region),
    .cmd_fill(cmd_fill), .cmd_data(cmd_data), .cmd_count(cmd_count), .array_read(array_read),
    .array_raddr(array_raddr), .array_rdata(array_rdata), .wd_valid(wd_valid), .wd_ready(wd_ready),
    .wd_data(wd_data));
  // ----------------------------------------
  // Capture and helpers
  // ----------------------------------------
  always @(posedge mclk) begin
    cyc++;
    if (cmd_reject === 1'b1) nr++;
    if (wd_valid === 1'b1 && wd_ready === 1'b1) wq.push_back(wd_data);
    if (cyc == 40000) begin
      err_total++;
      give_verdict();
    end
  end
  task automatic check(input string what, input logic [95:0] seen, input logic [95:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic sb(input logic [7:0] b);
    host.shift(b, 1, 8, rx);
  endtask
  task automatic hdr(input logic [7:0] op, input logic [23:0] a);
    host.start();
    sb(op);
    sb(a[23:16]);
    sb(a[15:8]);
    sb(a[7:0]);
  endtask
  task automatic bare(input logic [7:0] op);
    host.start();
    sb(op);
    host.stop();
  endtask
  task automatic write_enable_cmd();
    bare(`OPC_WRITE_ENABLE_CMD);
  endtask
  task automatic done();
    check("busy", busy, 1);
    @(posedge mclk) op_done <= 1'b1;
    @(posedge mclk) op_done <= 1'b0;
    repeat (3) @(posedge mclk);
    check("idle", busy, 0);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_latch();
    host.start();
    sb(`OPC_WRITE_ENABLE_CMD);
    host.shift(8'h00, 1, 1, rx);
    host.stop();
    check("nine clocks", write_enable_latch, 0);
    write_enable_cmd();
    check("set", write_enable_latch, 1);
    bare(8'hab);
    check("unknown", {write_enable_latch, busy}, 2'h2);
    bare(`OPC_WRITE_DISABLE_CMD);
    check("clear", write_enable_latch, 0);
  endtask
  task automatic t_prog();
    logic [7:0] ops [9] = '{8'h02, 8'h22, 8'hd1, 8'ha2, 8'hd3, 8'hd5, 8'h32, 8'hd7, 8'hd9};
    logic [23:0] a;
    int ln;
    for (int i = 0; i < 9; i++) begin
      a = {5'(i * 3), 19'h7ffc0 + 19'(i)};
      ln = 1 << (i / 3);
      wq.delete();
      write_enable_cmd();
      hdr(ops[i], a);
      host.shift(8'hc3 ^ 8'(i), ln, 8 / ln, rx);
      host.stop();
      check("kind", {cmd_kind, cmd_mode, cmd_lanes, cmd_fill, cmd_count}, {`KIND_PROGRAM, 2'(i % 3), 3'(ln), 15'h0001});
      check("map", {cmd_addr, cmd_sector, cmd_page, cmd_region}, {a, a[23:17], a[23:6], a[23:21]});
      check("byte", {wq.size(), wq[0]}, {32'h1, a[5:0], 8'hc3 ^ 8'(i)});
      done();
    end
  endtask
  task automatic t_busy();
    write_enable_cmd();
    hdr(`OPC_SECTOR_WIPE_CMD, 24'hfe1234);
    host.stop();
    check("wipe", {cmd_kind, cmd_fill, cmd_sector, cmd_region}, {`KIND_SECTOR_WIPE, 8'hff, 7'h7f, 3'h7});
    write_enable_cmd();
    check("busy write_enable_cmd", write_enable_latch, 0);
    host.start();
    sb(`OPC_STATUS_READ_CMD);
    sb(8'h00);
    host.stop();
    check("status", rx, 8'h01);
    hdr(`OPC_TWO_LINE_OUTPUT_READ, 24'h000010);
    sb(8'h00);
    check("busy read", array_read, 0);
    host.stop();
    done();
    write_enable_cmd();
    bare(`OPC_BULK_WIPE_CMD);
    check("bulk", {cmd_kind, cmd_fill}, {`KIND_BULK_WIPE, 8'hff});
    done();
    write_enable_cmd();
    host.start();
    sb(`OPC_STATUS_WRITE_CMD);
    sb(8'h3c);
    host.stop();
    check("swr", {cmd_kind, cmd_data, write_enable_latch}, {`KIND_STATUS_WRITE, 8'h3c, 1'b0});
    done();
  endtask
  task automatic t_reads();
    logic [7:0] ops [4] = '{8'h03, 8'h0b, 8'h3b, 8'h6b};
    int lns [4] = '{1, 1, 2, 4};
    logic [23:0] a;
    for (int i = 0; i < 4; i++) begin
      a = 24'h12345f + 24'(i * 7);
      hdr(ops[i], a);
      if (i > 0) sb(8'h00);
      host.shift(8'h00, lns[i], 8 / lns[i], rx);
      check("read", {array_read, rx}, {1'b1, a[7:0] ^ 8'ha5});
      host.shift(8'h00, lns[i], 3, rx);
      host.stop();
      check("oe", d_oe, 0);
    end
    host.start();
    sb(`OPC_IDENTITY_READ_CMD);
    sb(8'h00);
    host.stop();
    check("ident", rx, ID_M);
  endtask
  // Two entries fit while stalled; a third overruns
  task automatic t_stall(input int n);
    int r0;
    r0 = nr;
    wq.delete();
    wd_ready <= 1'b0;
    write_enable_cmd();
    hdr(`OPC_PROG_LEGACY, 24'h00003e);
    repeat (n) sb(8'h81);
    host.stop();
    check("stalled", {wd_valid, 32'(nr - r0)}, {1'b1, 32'(n > 2)});
    wd_ready <= 1'b1;
    repeat (5) @(posedge mclk);
    check("drained", wd_valid, 0);
    if (n == 2) begin
      check("pair", {wq[0], wq[1], cmd_count}, {14'h3e81, 14'h3f81, 7'h02});
      done();
    end else begin
      check("no busy", busy, 0);
      bare(`OPC_WRITE_DISABLE_CMD);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d errors %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  initial begin
    rst_n = 1'b0;
    op_done = 1'b0;
    wd_ready = 1'b1;
    repeat (10) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (4) @(posedge mclk);
    t_latch();
    t_prog();
    t_busy();
    t_reads();
    t_stall(2);
    t_stall(3);
    give_verdict();
  end
endmodule
`default_nettype wire

// ---- bench/spi_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Host serial controller
// ----------------------------------------
module spi_host_model (
  input wire logic mclk,
  input wire logic [3:0] io_in,
  output logic cs_n,
  output logic sclk,
  output logic [3:0] io_out
);
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    io_out = 4'h0;
  end
  task automatic start();
    @(posedge mclk) cs_n <= 1'b0;
    repeat (4) @(posedge mclk);
  endtask
  // Clock stands low between frames
  task automatic shift(input logic [7:0] tx, input int lanes, input int clocks, output logic [7:0] rx);
    logic [7:0] sh;
    sh = tx;
    rx = 8'h00;
    for (int k = 0; k < clocks; k++) begin
      @(posedge mclk) io_out <= 4'(sh[7:4] >> (4 - lanes));
      sh = sh << lanes;
      repeat (3) @(posedge mclk);
      sclk <= 1'b1;
      repeat (3) @(posedge mclk);
      @(negedge mclk) rx = (rx << lanes) | (8'(io_in >> (lanes == 1)) & 8'((1 << lanes) - 1));
      @(posedge mclk) sclk <= 1'b0;
    end
  endtask
  // May end in mid byte of a read
  task automatic stop();
    repeat (3) @(posedge mclk);
    cs_n <= 1'b1;
    io_out <= ~io_out;
    repeat (12) @(posedge mclk);
  endtask
endmodule
`default_nettype wire

// ---- common/pcm_decode_map.vh ----
`ifndef PCM_DECODE_MAP_VH
`define PCM_DECODE_MAP_VH

// ----------------------------------------
// Opcodes
// ----------------------------------------
`define OPC_WRITE_ENABLE_CMD 8'h06
`define OPC_WRITE_DISABLE_CMD 8'h04
`define OPC_IDENTITY_READ_CMD 8'h9f
`define OPC_IDENTITY_READ_ALT 8'h9e
`define OPC_STATUS_READ_CMD 8'h05
`define OPC_STATUS_WRITE_CMD 8'h01
`define OPC_PLAIN_READ 8'h03
`define OPC_FAST_READ 8'h0b
`define OPC_TWO_LINE_OUTPUT_READ 8'h3b
`define OPC_FOUR_LINE_OUTPUT_READ 8'h6b
`define OPC_PROG_LEGACY 8'h02
`define OPC_PROG_ALTER 8'h22
`define OPC_PROG_ONES 8'hd1
`define OPC_TWO_LINE_PROG_LEGACY 8'ha2
`define OPC_TWO_LINE_PROG_ALTER 8'hd3
`define OPC_TWO_LINE_PROG_ONES 8'hd5
`define OPC_FOUR_LINE_PROG_LEGACY 8'h32
`define OPC_FOUR_LINE_PROG_ALTER 8'hd7
`define OPC_FOUR_LINE_PROG_ONES 8'hd9
`define OPC_SECTOR_WIPE_CMD 8'hd8
`define OPC_BULK_WIPE_CMD 8'hc7

// ----------------------------------------
// Command kinds and write modes
// ----------------------------------------
`define KIND_NONE 4'h0
`define KIND_WRITE_ENABLE 4'h1
`define KIND_WRITE_DISABLE 4'h2
`define KIND_STATUS_READ 4'h3
`define KIND_STATUS_WRITE 4'h4
`define KIND_IDENTITY_READ 4'h5
`define KIND_ARRAY_READ 4'h6
`define KIND_PROGRAM 4'h7
`define KIND_SECTOR_WIPE 4'h8
`define KIND_BULK_WIPE 4'h9
`define MODE_LEGACY 2'h0
`define MODE_ALTER 2'h1
`define MODE_ONES 2'h2

// ----------------------------------------
// Array map
// ----------------------------------------
`define SECTOR_SHIFT 17
`define REGION_SHIFT 4
`define PAGE_SHIFT 6
`define PAGE_BYTES 7'h40
`define ADDR_LAST_BYTE 2'h2
`define ID_LAST_BYTE 2'h3
`define ERASED_BYTE 8'hff
`define BYTE_BITS 4'h8

// ----------------------------------------
// Write data buffer
// ----------------------------------------
`define FIFO_W 14
`define FIFO_DEPTH 2'h2

`endif

// ---- src/pcm_byte_fifo.v ----
`timescale 1ns/1ps
`default_nettype none
`include "pcm_decode_map.vh"

module pcm_byte_fifo #(
  parameter W = `FIFO_W,
  parameter [1:0] DEPTH = `FIFO_DEPTH
) (
  input wire mclk,
  input wire rst_n,
  input wire in_valid,
  output wire in_ready,
  input wire [W-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [W-1:0] out_data
);

  reg [W-1:0] mem [0:DEPTH-1];
  reg wptr;
  reg rptr;
  reg [1:0] count;
  wire push;
  wire pop;

  assign in_ready = count != DEPTH;
  assign out_valid = count != 2'h0;
  assign out_data = mem[rptr];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  always @(posedge mclk) begin
    if (push) begin
      mem[wptr] <= in_data;
    end
  end

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wptr <= 1'b0;
      rptr <= 1'b0;
      count <= 2'h0;
    end else begin
      if (push) begin
        wptr <= ~wptr;
      end
      if (pop) begin
        rptr <= ~rptr;
      end
      if (push && !pop) begin
        count <= count + 2'h1;
      end else if (pop && !push) begin
        count <= count - 2'h1;
      end
    end
  end

endmodule

`default_nettype wire

// ---- src/serial_pcm_instruction_decoder.v ----
`timescale 1ns/1ps
`default_nettype none
`include "pcm_decode_map.vh"

// Overview of operation
// - Sector number is address over 0x020000; 128 sectors.
// - Pages are 64 bytes; page number and in-page offset come from the address.
// - Eight regions of sixteen sectors; region is sector over sixteen.
// - Legacy program only clears bits; bit-alterable write sets or clears.
// - Sector and bulk wipe set every affected bit to one.
// - All opcode, address and data bits move most significant first.
// - First serial clock rise after select samples line zero, then each rise.
// - Opcode byte first, then address, dummy and data bytes per opcode.
// - Host may end any read at any bit; output stops on deselect.
// - Modifying commands execute only if deselect lands on a byte boundary.
// - Array access during a busy internal cycle is ignored.
// - Opcode 06h sets the write enable latch.
// - 3Bh reads with three address, one dummy byte, two output lines.
// - 6Bh reads with three address, one dummy byte, four output lines.
// - Page program opcodes 02h, 22h, D1h with address and 1 to 64 bytes.
// - Two-line program opcodes A2h, D3h, D5h with address and data.
// - Four-line program opcodes 32h, D7h, D9h with address and data.
// - Latch clears at reset and on write disable, status write, program, wipe.
// - While busy only the status read opcode is accepted.
module serial_pcm_instruction_decoder #(
  parameter [7:0] ID_MAKER = 8'h5a,
  parameter [7:0] ID_TYPE = 8'h3c,
  parameter [7:0] ID_CAPACITY = 8'h07
) (
  input wire mclk,
  input wire rst_n,
  input wire cs_n,
  input wire sclk,
  input wire io_line_0_i,
  input wire io_line_1_i,
  input wire io_line_2_i,
  input wire io_line_3_i,
  output reg io_line_0_o,
  output reg io_line_1_o,
  output reg io_line_2_o,
  output reg io_line_3_o,
  output reg io_line_0_oe,
  output reg io_line_1_oe,
  output reg io_line_2_oe,
  output reg io_line_3_oe,
  output reg write_enable_latch,
  output reg busy,
  input wire op_done,
  output reg cmd_valid,
  output reg cmd_reject,
  output reg [3:0] cmd_kind,
  output reg [1:0] cmd_mode,
  output reg [2:0] cmd_lanes,
  output reg [23:0] cmd_addr,
  output reg [6:0] cmd_sector,
  output reg [17:0] cmd_page,
  output reg [2:0] cmd_region,
  output reg [7:0] cmd_fill,
  output reg [7:0] cmd_data,
  output reg [6:0] cmd_count,
  output reg array_read,
  output reg [23:0] array_raddr,
  input wire [7:0] array_rdata,
  output wire wd_valid,
  input wire wd_ready,
  output wire [13:0] wd_data
);

  // ----------------------------------------
  // States
  // ----------------------------------------
  localparam [2:0] ST_OPC = 3'h0;
  localparam [2:0] ST_ADDR = 3'h1;
  localparam [2:0] ST_DUMMY = 3'h2;
  localparam [2:0] ST_DIN = 3'h3;
  localparam [2:0] ST_DOUT = 3'h4;
  localparam [2:0] ST_END = 3'h5;
  localparam [2:0] ST_SKIP = 3'h6;

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  reg [5:0] sync1;
  reg [5:0] sync2;
  reg cs_d;
  reg ck_d;
  wire cs_s = sync2[0];
  wire ck_s = sync2[1];
  wire [3:0] io_s = sync2[5:2];
  wire rise = ck_s & ~ck_d & ~cs_s;
  wire fall = ~ck_s & ck_d & ~cs_s;
  wire frame_end = cs_s & ~cs_d;

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sync1 <= 6'h01;
      sync2 <= 6'h01;
      cs_d <= 1'b1;
      ck_d <= 1'b0;
    end else begin
      sync1 <= {io_line_3_i, io_line_2_i, io_line_1_i, io_line_0_i, sclk, cs_n};
      sync2 <= sync1;
      cs_d <= cs_s;
      ck_d <= ck_s;
    end
  end

  // ----------------------------------------
  // Frame state
  // ----------------------------------------
  reg [2:0] state;
  reg [7:0] opc;
  reg [7:0] sh;
  reg [3:0] bitcnt;
  reg [1:0] bytecnt;
  reg [23:0] addr;
  reg [6:0] ndata;
  reg ovr;
  reg [7:0] oshr;
  reg [3:0] ocnt;
  reg [1:0] idx;

  // ----------------------------------------
  // Opcode decode
  // ----------------------------------------
  reg [3:0] d_kind;
  reg d_addr;
  reg d_dummy;
  reg d_in;
  reg d_out;
  reg d_mod;
  reg d_wel;
  reg [2:0] d_lanes;
  reg [1:0] d_mode;
  reg [7:0] next_sh;
  wire [7:0] dec_in = (state == ST_OPC) ? next_sh : opc;

  always @* begin
    d_kind = `KIND_NONE;
    d_addr = 1'b0;
    d_dummy = 1'b0;
    d_in = 1'b0;
    d_out = 1'b0;
    d_lanes = 3'h1;
    d_mode = `MODE_LEGACY;
    case (dec_in)
      `OPC_WRITE_ENABLE_CMD: d_kind = `KIND_WRITE_ENABLE;
      `OPC_WRITE_DISABLE_CMD: d_kind = `KIND_WRITE_DISABLE;
      `OPC_STATUS_READ_CMD: begin
        d_kind = `KIND_STATUS_READ;
        d_out = 1'b1;
      end
      `OPC_STATUS_WRITE_CMD: begin
        d_kind = `KIND_STATUS_WRITE;
        d_in = 1'b1;
      end
      `OPC_IDENTITY_READ_CMD, `OPC_IDENTITY_READ_ALT: begin
        d_kind = `KIND_IDENTITY_READ;
        d_out = 1'b1;
      end
      `OPC_PLAIN_READ: begin
        d_kind = `KIND_ARRAY_READ;
        d_addr = 1'b1;
        d_out = 1'b1;
      end
      `OPC_FAST_READ, `OPC_TWO_LINE_OUTPUT_READ, `OPC_FOUR_LINE_OUTPUT_READ: begin
        d_kind = `KIND_ARRAY_READ;
        d_addr = 1'b1;
        d_dummy = 1'b1;
        d_out = 1'b1;
        if (dec_in == `OPC_TWO_LINE_OUTPUT_READ) begin
          d_lanes = 3'h2;
        end else if (dec_in == `OPC_FOUR_LINE_OUTPUT_READ) begin
          d_lanes = 3'h4;
        end
      end
      `OPC_PROG_LEGACY, `OPC_PROG_ALTER, `OPC_PROG_ONES: begin
        d_kind = `KIND_PROGRAM;
        d_addr = 1'b1;
        d_in = 1'b1;
      end
      `OPC_TWO_LINE_PROG_LEGACY, `OPC_TWO_LINE_PROG_ALTER, `OPC_TWO_LINE_PROG_ONES: begin
        d_kind = `KIND_PROGRAM;
        d_addr = 1'b1;
        d_in = 1'b1;
        d_lanes = 3'h2;
      end
      `OPC_FOUR_LINE_PROG_LEGACY, `OPC_FOUR_LINE_PROG_ALTER, `OPC_FOUR_LINE_PROG_ONES: begin
        d_kind = `KIND_PROGRAM;
        d_addr = 1'b1;
        d_in = 1'b1;
        d_lanes = 3'h4;
      end
      `OPC_SECTOR_WIPE_CMD: begin
        d_kind = `KIND_SECTOR_WIPE;
        d_addr = 1'b1;
      end
      `OPC_BULK_WIPE_CMD: d_kind = `KIND_BULK_WIPE;
      default: d_kind = `KIND_NONE;
    endcase
    case (dec_in)
      `OPC_PROG_ALTER, `OPC_TWO_LINE_PROG_ALTER, `OPC_FOUR_LINE_PROG_ALTER: d_mode = `MODE_ALTER;
      `OPC_PROG_ONES, `OPC_TWO_LINE_PROG_ONES, `OPC_FOUR_LINE_PROG_ONES: d_mode = `MODE_ONES;
      default: d_mode = `MODE_LEGACY;
    endcase
    d_mod = (d_kind == `KIND_WRITE_ENABLE) || (d_kind == `KIND_WRITE_DISABLE) ||
            (d_kind == `KIND_STATUS_WRITE) || (d_kind == `KIND_PROGRAM) ||
            (d_kind == `KIND_SECTOR_WIPE) || (d_kind == `KIND_BULK_WIPE);
    d_wel = d_mod && (d_kind != `KIND_WRITE_ENABLE) && (d_kind != `KIND_WRITE_DISABLE);
  end

  // ----------------------------------------
  // Input shifting
  // ----------------------------------------
  // Opcode, address and dummy bytes always use line zero
  wire [2:0] in_lanes = (state == ST_DIN) ? d_lanes : 3'h1;
  wire [3:0] next_bitcnt = bitcnt + {1'b0, in_lanes};
  wire byte_done = next_bitcnt == `BYTE_BITS;
  wire [23:0] next_addr = {addr[15:0], next_sh};

  always @* begin
    case (in_lanes)
      3'h2: next_sh = {sh[5:0], io_s[1], io_s[0]};
      3'h4: next_sh = {sh[3:0], io_s};
      default: next_sh = {sh[6:0], io_s[0]};
    endcase
  end

  // ----------------------------------------
  // Write data buffer
  // ----------------------------------------
  // Offset wraps inside the page; ndata holds at 64, so every byte past the 64th lands on the starting offset
  wire [5:0] page_off = addr[5:0] + ndata[5:0];
  wire push = rise & byte_done & (state == ST_DIN) & (d_kind == `KIND_PROGRAM);
  wire push_ready;

  pcm_byte_fifo wbuf (
    .mclk(mclk),
    .rst_n(rst_n),
    .in_valid(push),
    .in_ready(push_ready),
    .in_data({page_off, next_sh}),
    .out_valid(wd_valid),
    .out_ready(wd_ready),
    .out_data(wd_data)
  );

  // ----------------------------------------
  // Output byte source
  // ----------------------------------------
  reg [7:0] fresh;
  reg [7:0] cur_shift;
  wire [7:0] cur = (ocnt == 4'h0) ? fresh : oshr;
  wire [3:0] next_ocnt = ocnt + {1'b0, d_lanes};
  wire [23:0] sec_full = addr >> `SECTOR_SHIFT;
  wire [6:0] region_full = sec_full[6:0] >> `REGION_SHIFT;
  wire [23:0] page_full = addr >> `PAGE_SHIFT;

  always @* begin
    case (d_kind)
      `KIND_STATUS_READ: fresh = {6'h00, write_enable_latch, busy};
      `KIND_IDENTITY_READ: begin
        case (idx)
          2'h0: fresh = ID_MAKER;
          2'h1: fresh = ID_TYPE;
          2'h2: fresh = ID_CAPACITY;
          default: fresh = 8'h00;
        endcase
      end
      `KIND_ARRAY_READ: fresh = array_rdata;
      default: fresh = 8'h00;
    endcase
    case (d_lanes)
      3'h2: cur_shift = {cur[5:0], 2'h0};
      3'h4: cur_shift = {cur[3:0], 4'h0};
      default: cur_shift = {cur[6:0], 1'b0};
    endcase
  end

  // ----------------------------------------
  // Main sequencer
  // ----------------------------------------
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_OPC;
      opc <= 8'h00;
      sh <= 8'h00;
      bitcnt <= 4'h0;
      bytecnt <= 2'h0;
      addr <= 24'h000000;
      ndata <= 7'h00;
      ovr <= 1'b0;
      oshr <= 8'h00;
      ocnt <= 4'h0;
      idx <= 2'h0;
      io_line_0_o <= 1'b0;
      io_line_1_o <= 1'b0;
      io_line_2_o <= 1'b0;
      io_line_3_o <= 1'b0;
      io_line_0_oe <= 1'b0;
      io_line_1_oe <= 1'b0;
      io_line_2_oe <= 1'b0;
      io_line_3_oe <= 1'b0;
      write_enable_latch <= 1'b0;
      busy <= 1'b0;
      cmd_valid <= 1'b0;
      cmd_reject <= 1'b0;
      cmd_kind <= `KIND_NONE;
      cmd_mode <= `MODE_LEGACY;
      cmd_lanes <= 3'h1;
      cmd_addr <= 24'h000000;
      cmd_sector <= 7'h00;
      cmd_page <= 18'h00000;
      cmd_region <= 3'h0;
      cmd_fill <= 8'h00;
      cmd_data <= 8'h00;
      cmd_count <= 7'h00;
      array_read <= 1'b0;
      array_raddr <= 24'h000000;
    end else begin
      cmd_valid <= 1'b0;
      cmd_reject <= 1'b0;
      if (op_done) begin
        busy <= 1'b0;
      end
      if (cs_s) begin
        // Deselect ends any output at once
        io_line_0_oe <= 1'b0;
        io_line_1_oe <= 1'b0;
        io_line_2_oe <= 1'b0;
        io_line_3_oe <= 1'b0;
        array_read <= 1'b0;
        state <= ST_OPC;
        bitcnt <= 4'h0;
        bytecnt <= 2'h0;
        ndata <= 7'h00;
        ovr <= 1'b0;
        ocnt <= 4'h0;
        idx <= 2'h0;
        if (frame_end && d_mod && ((state == ST_DIN) || (state == ST_END))) begin
          if ((bitcnt == 4'h0) && !ovr && (!d_in || (ndata != 7'h00))) begin
            case (d_kind)
              `KIND_WRITE_ENABLE: write_enable_latch <= 1'b1;
              `KIND_WRITE_DISABLE: write_enable_latch <= 1'b0;
              default: begin
                write_enable_latch <= 1'b0;
                busy <= 1'b1;
                cmd_valid <= 1'b1;
              end
            endcase
            cmd_kind <= d_kind;
            cmd_mode <= d_mode;
            cmd_lanes <= d_lanes;
            cmd_addr <= addr;
            cmd_sector <= sec_full[6:0];
            cmd_page <= page_full[17:0];
            cmd_region <= region_full[2:0];
            cmd_count <= ndata;
            if ((d_kind == `KIND_SECTOR_WIPE) || (d_kind == `KIND_BULK_WIPE)) begin
              cmd_fill <= `ERASED_BYTE;
            end else begin
              cmd_fill <= 8'h00;
            end
          end else if (d_in) begin
            cmd_reject <= 1'b1;
          end
        end
      end else if (rise) begin
        sh <= next_sh;
        bitcnt <= byte_done ? 4'h0 : next_bitcnt;
        if (byte_done) begin
          case (state)
            ST_OPC: begin
              opc <= next_sh;
              if (d_kind == `KIND_NONE) begin
                state <= ST_SKIP;
              end else if (busy && (d_kind != `KIND_STATUS_READ)) begin
                state <= ST_SKIP;
              end else if (d_wel && !write_enable_latch) begin
                state <= ST_SKIP;
              end else if (d_addr) begin
                state <= ST_ADDR;
              end else if (d_out) begin
                state <= ST_DOUT;
              end else if (d_in) begin
                state <= ST_DIN;
              end else begin
                state <= ST_END;
              end
            end
            ST_ADDR: begin
              addr <= next_addr;
              bytecnt <= bytecnt + 2'h1;
              if (bytecnt == `ADDR_LAST_BYTE) begin
                array_raddr <= next_addr;
                if (d_dummy) begin
                  state <= ST_DUMMY;
                end else if (d_out) begin
                  state <= ST_DOUT;
                  array_read <= 1'b1;
                end else if (d_in) begin
                  state <= ST_DIN;
                end else begin
                  state <= ST_END;
                end
              end
            end
            ST_DUMMY: begin
              state <= ST_DOUT;
              array_read <= 1'b1;
            end
            ST_DIN: begin
              if ((d_kind == `KIND_STATUS_WRITE) && (ndata == 7'h00)) begin
                cmd_data <= next_sh;
              end
              if (ndata != `PAGE_BYTES) begin
                ndata <= ndata + 7'h01;
              end
              // A full buffer would drop a byte, so the command is refused instead
              if (push && !push_ready) begin
                ovr <= 1'b1;
              end
            end
            default: state <= state;
          endcase
        end
      end else if (fall && (state == ST_DOUT)) begin
        oshr <= cur_shift;
        ocnt <= (next_ocnt == `BYTE_BITS) ? 4'h0 : next_ocnt;
        if (ocnt == 4'h0) begin
          if (d_kind == `KIND_ARRAY_READ) begin
            array_raddr <= array_raddr + 24'h000001;
          end
          if ((d_kind == `KIND_IDENTITY_READ) && (idx != `ID_LAST_BYTE)) begin
            idx <= idx + 2'h1;
          end
        end
        io_line_1_o <= cur[7];
        io_line_1_oe <= 1'b1;
        if (d_lanes == 3'h2) begin
          io_line_0_o <= cur[6];
          io_line_0_oe <= 1'b1;
        end else if (d_lanes == 3'h4) begin
          io_line_3_o <= cur[7];
          io_line_2_o <= cur[6];
          io_line_1_o <= cur[5];
          io_line_0_o <= cur[4];
          io_line_3_oe <= 1'b1;
          io_line_2_oe <= 1'b1;
          io_line_0_oe <= 1'b1;
        end
      end
    end
  end

endmodule

`default_nettype wire
